// file: pkg/dplc_pkg.sv
// Shared constants and state types for the phase link control ends.
// Assumes a 20 MHz core clock on both ends of the link.
package dplc_pkg;
  localparam int CORE_CLK_PS = 50000;
  localparam int DIF_PER_MIN_NS = 200;
  localparam int DIF_PER_MAX_NS = 1100;
  localparam int DIF_FULL_NS = 250;
  localparam int DIF_IDLE_NS = 1000;
  localparam int DIS_LOW_NS = 40000;
  localparam int STARTUP_NS = 200000;
  localparam int DIF_PER_MIN_CYC = (DIF_PER_MIN_NS * 1000 + CORE_CLK_PS - 1) / CORE_CLK_PS;
  localparam int DIF_PER_MAX_CYC = (DIF_PER_MAX_NS * 1000) / CORE_CLK_PS;
  localparam int DIF_FULL_CYC = (DIF_FULL_NS * 1000) / CORE_CLK_PS;
  localparam int DIF_IDLE_CYC = (DIF_IDLE_NS * 1000) / CORE_CLK_PS;
  localparam int DIS_LOW_CYC = (DIS_LOW_NS * 1000 + CORE_CLK_PS - 1) / CORE_CLK_PS;
  localparam int STARTUP_CYC = (STARTUP_NS * 1000 + CORE_CLK_PS - 1) / CORE_CLK_PS;
  localparam logic [4:0] PER_MIN_C = 5'(DIF_PER_MIN_CYC);
  localparam logic [4:0] PER_MAX_C = 5'(DIF_PER_MAX_CYC);
  localparam logic [4:0] FULL_C = 5'(DIF_FULL_CYC);
  localparam logic [4:0] IDLE_C = 5'(DIF_IDLE_CYC);
  localparam logic [9:0] DIS_LOW_C = 10'(DIS_LOW_CYC);
  localparam logic [11:0] STARTUP_C = 12'(STARTUP_CYC);
  // Duty window 1/6 .. 5/6 of the period
  localparam logic [7:0] DUTY_DEN = 8'h06;
  localparam logic [7:0] DUTY_MAX = 8'h05;
  // Command pulse lengths in timing clock periods with the line low
  localparam logic [3:0] CMD_ON = 4'h1;
  localparam logic [3:0] CMD_QUERY = 4'h2;
  localparam logic [3:0] CMD_CNT_BASE = 4'h2;
  localparam logic [3:0] CMD_CNT_LAST = 4'h6;
  localparam logic [3:0] CMD_SHED_BASE = 4'h7;
  localparam logic [3:0] CMD_LEN_MAX = 4'hf;
  localparam logic [2:0] NUM_SLOTS = 3'h4;
  localparam logic [2:0] RESP_END = 3'h5;
  localparam int ID_INTEG_BIT = 2;
  typedef enum logic [1:0] {
    DPLC_DIS = 2'b00,
    DPLC_IDM = 2'b01,
    DPLC_CFG = 2'b10,
    DPLC_RUN = 2'b11
  } dplc_dev_st_t;
  typedef enum logic [2:0] {
    DPLC_H_OFF = 3'b000,
    DPLC_H_WAIT = 3'b001,
    DPLC_H_QTX = 3'b010,
    DPLC_H_QRX = 3'b011,
    DPLC_H_BTX = 3'b100,
    DPLC_H_RUN = 3'b101,
    DPLC_H_CTX = 3'b110
  } dplc_host_st_t;
endpackage

// file: pkg/dplc_link_if.sv
// Two-wire link between host and one device end.
// Control line is open drain with a pull-up modelled here.
`timescale 1ns/1ps
`default_nettype none
interface dplc_link_if;
  logic timing_duty_line;
  logic host_ctl_o;
  logic host_ctl_oe_n;
  logic dev_ctl_o;
  logic dev_ctl_oe_n;
  wire logic ctl_handshake_line;
  assign ctl_handshake_line = ~((~host_ctl_oe_n & ~host_ctl_o) | (~dev_ctl_oe_n & ~dev_ctl_o));
  modport host (
    output timing_duty_line,
    output host_ctl_o,
    output host_ctl_oe_n,
    input ctl_handshake_line
  );
  modport dev (
    input timing_duty_line,
    input ctl_handshake_line,
    output dev_ctl_o,
    output dev_ctl_oe_n
  );
endinterface
`default_nettype wire

// file: design/dplc_host.sv
// Host end: drives the timing clock, initialises and sheds phases.
// Assumes user inputs are on core_clk; link line comes from outside.
`timescale 1ns/1ps
`default_nettype none
module dplc_host (
  input wire logic core_clk,
  input wire logic nrst,
  dplc_link_if.host link,
  input wire logic rail_en,
  input wire logic [2:0] phases_req,
  input wire logic [4:0] duty_hi,
  output logic [2:0] dev_count,
  output logic init_done,
  output logic [2:0] phases_on
);
  function automatic logic [2:0] dplc_popcnt(input logic [3:0] b);
    dplc_popcnt = 3'({2'b0, b[0]} + {2'b0, b[1]} + {2'b0, b[2]} + {2'b0, b[3]});
  endfunction

  dplc_pkg::dplc_host_st_t st_r, st_nxt;
  logic ctl_s1_r, ctl_s2_r;
  logic [4:0] div_r;
  logic full_r, dif_r, dif_q_r;
  logic drv_r, pend_r, tx_done_r;
  logic [3:0] tx_len_r, tx_cnt_r, len_nxt;
  logic [11:0] wait_r;
  logic [2:0] fc_r, cnt_r, on_r, on_pend_r, on_nxt;
  logic [3:0] bits_r, q1_r;
  logic rep_r;

  wire logic rise = dif_r & ~dif_q_r;
  wire logic fall = ~dif_r & dif_q_r;
  wire logic running = (st_r == dplc_pkg::DPLC_H_RUN) | (st_r == dplc_pkg::DPLC_H_CTX);
  wire logic want_full = running & (on_r != 3'h0);
  wire logic [4:0] per = full_r ? dplc_pkg::FULL_C : dplc_pkg::IDLE_C;
  // One-cycle high or low phases would be dropped as runts by the device
  wire logic [4:0] hi_full = (duty_hi <= 5'h2) ? 5'h2 :
                             (duty_hi >= dplc_pkg::FULL_C - 5'h2) ? dplc_pkg::FULL_C - 5'h2 :
                             duty_hi;
  wire logic [4:0] hi = full_r ? hi_full : {1'b0, dplc_pkg::IDLE_C[4:1]};
  wire logic wrap = div_r == per - 5'h1;
  wire logic [4:0] div_nxt = wrap ? 5'h0 : div_r + 5'h1;
  wire logic q_last = (st_r == dplc_pkg::DPLC_H_QRX) & rise & (fc_r == dplc_pkg::NUM_SLOTS);
  wire logic [3:0] bits_fin = {~ctl_s2_r, bits_r[2:0]};
  wire logic q_ok = rep_r & (bits_fin == q1_r) & (bits_fin != 4'h0);

  assign link.timing_duty_line = dif_r;
  assign link.host_ctl_o = 1'b0;
  assign link.host_ctl_oe_n = ~(drv_r | (st_r == dplc_pkg::DPLC_H_OFF));
  assign dev_count = cnt_r;
  assign phases_on = on_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_s1_r <= 1'b1;
      ctl_s2_r <= 1'b1;
    end else begin
      ctl_s1_r <= link.ctl_handshake_line;
      ctl_s2_r <= ctl_s1_r;
    end
  end

  // Timing clock: stopped low while rail off, full or idle rate
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 5'h0;
      full_r <= 1'b0;
      dif_r <= 1'b0;
      dif_q_r <= 1'b0;
    end else begin
      dif_q_r <= dif_r;
      if (st_r == dplc_pkg::DPLC_H_OFF) begin
        div_r <= 5'h0;
        dif_r <= 1'b0;
      end else begin
        div_r <= div_nxt;
        dif_r <= div_nxt < hi;
        if (wrap) full_r <= want_full;
      end
    end
  end

  // Command sender: line low from a fall for tx_len rises
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drv_r <= 1'b0;
      pend_r <= 1'b0;
      tx_cnt_r <= 4'h0;
      tx_len_r <= 4'h0;
      tx_done_r <= 1'b0;
    end else begin
      tx_done_r <= 1'b0;
      if (st_r == dplc_pkg::DPLC_H_OFF) begin
        drv_r <= 1'b0;
        pend_r <= 1'b0;
      end else if (st_nxt != st_r && (st_nxt == dplc_pkg::DPLC_H_QTX ||
                   st_nxt == dplc_pkg::DPLC_H_BTX || st_nxt == dplc_pkg::DPLC_H_CTX)) begin
        pend_r <= 1'b1;
        tx_len_r <= len_nxt;
      end else if (fall && pend_r && !drv_r && ctl_s2_r) begin
        // Start only on a released line so a late slot answer is not overrun
        drv_r <= 1'b1;
        pend_r <= 1'b0;
        tx_cnt_r <= 4'h0;
      end else if (fall && drv_r && tx_cnt_r == tx_len_r) begin
        drv_r <= 1'b0;
        tx_done_r <= 1'b1;
      end else if (rise && drv_r) begin
        tx_cnt_r <= tx_cnt_r + 4'h1;
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    len_nxt = dplc_pkg::CMD_QUERY;
    on_nxt = on_r;
    case (st_r)
      dplc_pkg::DPLC_H_OFF: if (rail_en) st_nxt = dplc_pkg::DPLC_H_WAIT;
      dplc_pkg::DPLC_H_WAIT: if (wait_r >= dplc_pkg::STARTUP_C) st_nxt = dplc_pkg::DPLC_H_QTX;
      dplc_pkg::DPLC_H_QTX: if (tx_done_r) st_nxt = dplc_pkg::DPLC_H_QRX;
      dplc_pkg::DPLC_H_QRX: begin
        if (q_last && q_ok) begin
          st_nxt = dplc_pkg::DPLC_H_BTX;
          len_nxt = dplc_pkg::CMD_CNT_BASE + {1'b0, dplc_popcnt(bits_fin)};
        end else if (q_last) begin
          st_nxt = dplc_pkg::DPLC_H_QTX;
        end
      end
      dplc_pkg::DPLC_H_BTX: if (tx_done_r) st_nxt = dplc_pkg::DPLC_H_RUN;
      dplc_pkg::DPLC_H_RUN: begin
        if (phases_req > on_r && on_r == 3'h0) begin
          st_nxt = dplc_pkg::DPLC_H_CTX;
          len_nxt = dplc_pkg::CMD_ON;
          on_nxt = cnt_r;
        end else if (phases_req < on_r) begin
          st_nxt = dplc_pkg::DPLC_H_CTX;
          len_nxt = dplc_pkg::CMD_SHED_BASE + {1'b0, on_r} - 4'h1;
          on_nxt = on_r - 3'h1;
        end
      end
      dplc_pkg::DPLC_H_CTX: if (tx_done_r) st_nxt = dplc_pkg::DPLC_H_RUN;
      default: st_nxt = dplc_pkg::DPLC_H_OFF;
    endcase
    if (!rail_en) st_nxt = dplc_pkg::DPLC_H_OFF;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= dplc_pkg::DPLC_H_OFF;
      wait_r <= 12'h0;
      fc_r <= 3'h0;
      bits_r <= 4'h0;
      q1_r <= 4'h0;
      rep_r <= 1'b0;
      cnt_r <= 3'h0;
      on_r <= 3'h0;
      on_pend_r <= 3'h0;
      init_done <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wait_r <= (st_r == dplc_pkg::DPLC_H_WAIT) ? wait_r + 12'h1 : 12'h0;
      if (st_r == dplc_pkg::DPLC_H_OFF) begin
        rep_r <= 1'b0;
        cnt_r <= 3'h0;
        on_r <= 3'h0;
        init_done <= 1'b0;
      end
      if (st_r != dplc_pkg::DPLC_H_QRX) begin
        fc_r <= 3'h0;
        bits_r <= 4'h0;
      end else if (fall) begin
        fc_r <= fc_r + 3'h1;
      end else if (rise && fc_r != 3'h0) begin
        bits_r[fc_r[1:0] - 2'h1] <= ~ctl_s2_r;
      end
      if (q_last) begin
        q1_r <= bits_fin;
        rep_r <= 1'b1;
        if (q_ok) cnt_r <= dplc_popcnt(bits_fin);
      end
      if (st_r == dplc_pkg::DPLC_H_BTX && tx_done_r) init_done <= 1'b1;
      if (st_r == dplc_pkg::DPLC_H_RUN && st_nxt == dplc_pkg::DPLC_H_CTX) on_pend_r <= on_nxt;
      if (st_r == dplc_pkg::DPLC_H_CTX && tx_done_r) on_r <= on_pend_r;
    end
  end
endmodule
`default_nettype wire

// file: design/dplc_dev.sv
// Device end: phase slot, switch timing and link handling of one unit.
// Assumes analog ID converter, thermal sensor and rail monitor as async inputs.
`timescale 1ns/1ps
`default_nettype none
module dplc_dev (
  input wire logic core_clk,
  input wire logic nrst,
  dplc_link_if.dev link,
  input wire logic [2:0] id_adc_code,
  input wire logic id_adc_valid,
  output logic id_src_en,
  input wire logic over_temp,
  input wire logic rail_on,
  output logic sw_high,
  output logic sw_low,
  output logic phase_active,
  output logic [1:0] device_id,
  output logic configured,
  output logic thermal_off
);
  function automatic logic [6:0] dplc_slot_off(input logic [6:0] per, input logic [1:0] slot,
                                               input logic [2:0] n);
    logic [8:0] prod;
    prod = {2'b0, per} * {7'h0, slot};
    dplc_slot_off = (n == 3'h0) ? 7'h0 : 7'(prod / {6'h0, n});
  endfunction

  dplc_pkg::dplc_dev_st_t st_r, st_nxt;
  logic [7:0] s1_r, s2_r;
  logic dif_d_r, dif_f_r, dio_d_r, dio_f_r;
  logic dif_fq_r, dio_fq_r;
  logic [4:0] per_cnt_r, hi_meas_r, per_r, hi_r;
  logic good_r, tog_r;
  logic [6:0] sw_cnt_r;
  logic [3:0] len_r;
  logic [9:0] low_cnt_r;
  logic [1:0] id_r;
  logic integ_r;
  logic [2:0] count_r, fc_r;
  logic armed_r, resp_r, phase_on_r, tsd_r;

  // Synchronised inputs, bit 0 timing line, bit 1 control line
  wire logic dif_s = s2_r[0];
  wire logic dio_s = s2_r[1];
  wire logic temp_s = s2_r[2];
  wire logic rail_s = s2_r[3];
  wire logic adc_vld_s = s2_r[4];
  wire logic [2:0] adc_code_s = s2_r[7:5];

  wire logic dif_rise = dif_f_r & ~dif_fq_r;
  wire logic dif_fall = ~dif_f_r & dif_fq_r;
  wire logic dio_rise = dio_f_r & ~dio_fq_r;
  wire logic dio_fall = ~dio_f_r & dio_fq_r;

  wire logic [7:0] per8 = {3'h0, per_cnt_r};
  wire logic [7:0] hi6 = 8'({3'h0, hi_meas_r} * dplc_pkg::DUTY_DEN);
  wire logic per_ok = per_cnt_r >= dplc_pkg::PER_MIN_C && per_cnt_r <= dplc_pkg::PER_MAX_C;
  wire logic duty_ok = hi6 >= per8 && hi6 <= 8'(per8 * dplc_pkg::DUTY_MAX);
  wire logic dif_good = dif_rise & per_ok & duty_ok;
  wire logic dif_live = per_cnt_r <= dplc_pkg::PER_MAX_C;

  wire logic [1:0] slot = integ_r ? 2'h0 : id_r;
  wire logic [2:0] nslots = integ_r ? 3'h1 : count_r;
  wire logic [6:0] swper = {1'b0, per_r, 1'b0};
  wire logic [6:0] off_raw = dplc_slot_off(swper, slot, nslots);
  wire logic [6:0] off = (off_raw >= swper) ? 7'h0 : off_raw;
  wire logic [6:0] rel = (sw_cnt_r >= off) ? sw_cnt_r - off : sw_cnt_r + swper - off;
  wire logic [6:0] on_len = {1'b0, hi_r, 1'b0};
  wire logic sw_en = (st_r == dplc_pkg::DPLC_RUN) & phase_on_r & good_r & ~tsd_r;
  wire logic hs_nxt = sw_en & (rel < on_len);

  wire logic cmd_query = dio_rise & (len_r == dplc_pkg::CMD_QUERY);
  wire logic cmd_cnt = dio_rise & (len_r > dplc_pkg::CMD_CNT_BASE) &
                       (len_r <= dplc_pkg::CMD_CNT_LAST);
  wire logic cmd_on = dio_rise & (len_r == dplc_pkg::CMD_ON);
  wire logic cmd_shed = dio_rise & (len_r == dplc_pkg::CMD_SHED_BASE + {2'h0, slot});
  wire logic dis_hit = low_cnt_r >= dplc_pkg::DIS_LOW_C;
  wire logic cfgd = (st_r == dplc_pkg::DPLC_CFG) | (st_r == dplc_pkg::DPLC_RUN);

  assign link.dev_ctl_o = 1'b0;
  assign link.dev_ctl_oe_n = ~resp_r;
  assign id_src_en = st_r == dplc_pkg::DPLC_IDM;
  assign phase_active = sw_en;
  assign device_id = id_r;
  assign configured = st_r == dplc_pkg::DPLC_RUN;
  assign thermal_off = tsd_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 8'h0;
      s2_r <= 8'h0;
    end else begin
      s1_r <= {id_adc_code, id_adc_valid, rail_on, over_temp, link.ctl_handshake_line,
               link.timing_duty_line};
      s2_r <= s1_r;
    end
  end

  // One-sample pulses on either line never reach the filtered level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dif_d_r <= 1'b0;
      dif_f_r <= 1'b0;
      dio_d_r <= 1'b0;
      dio_f_r <= 1'b0;
      dif_fq_r <= 1'b0;
      dio_fq_r <= 1'b0;
    end else begin
      dif_d_r <= dif_s;
      dio_d_r <= dio_s;
      if (dif_s == dif_d_r) dif_f_r <= dif_s;
      if (dio_s == dio_d_r) dio_f_r <= dio_s;
      dif_fq_r <= dif_f_r;
      dio_fq_r <= dio_f_r;
    end
  end

  // Period and high time of each timing clock cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      per_cnt_r <= 5'h1f;
      hi_meas_r <= 5'h0;
      per_r <= dplc_pkg::FULL_C;
      hi_r <= 5'h0;
      good_r <= 1'b0;
    end else begin
      if (dif_rise) per_cnt_r <= 5'h1;
      else if (per_cnt_r != 5'h1f) per_cnt_r <= per_cnt_r + 5'h1;
      if (dif_fall) hi_meas_r <= per_cnt_r;
      if (dif_good) begin
        per_r <= per_cnt_r;
        hi_r <= hi_meas_r;
        good_r <= 1'b1;
      end else if (!dif_live) begin
        good_r <= 1'b0;
      end
    end
  end

  // Switching period of two clocks, aligned by each command end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tog_r <= 1'b0;
      sw_cnt_r <= 7'h0;
      sw_high <= 1'b0;
      sw_low <= 1'b0;
    end else begin
      if (dio_rise) tog_r <= 1'b0;
      else if (dif_good) tog_r <= ~tog_r;
      if (dif_good && !tog_r && !dio_rise) sw_cnt_r <= 7'h0;
      else if (sw_cnt_r != 7'h7f) sw_cnt_r <= sw_cnt_r + 7'h1;
      sw_high <= hs_nxt;
      sw_low <= sw_en & ~hs_nxt;
    end
  end

  // Command length in valid timing clock periods with the line low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      len_r <= 4'h0;
      low_cnt_r <= 10'h0;
    end else begin
      if (dio_fall) len_r <= 4'h0;
      else if (!dio_f_r && dif_good && len_r != dplc_pkg::CMD_LEN_MAX) len_r <= len_r + 4'h1;
      if (dio_f_r) low_cnt_r <= 10'h0;
      else if (!dis_hit) low_cnt_r <= low_cnt_r + 10'h1;
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      dplc_pkg::DPLC_DIS: if (dio_f_r) st_nxt = dplc_pkg::DPLC_IDM;
      dplc_pkg::DPLC_IDM: if (adc_vld_s) st_nxt = dplc_pkg::DPLC_CFG;
      dplc_pkg::DPLC_CFG: if (cmd_cnt) st_nxt = dplc_pkg::DPLC_RUN;
      dplc_pkg::DPLC_RUN: if (cmd_cnt) st_nxt = dplc_pkg::DPLC_RUN;
      default: st_nxt = dplc_pkg::DPLC_DIS;
    endcase
    if (dis_hit) st_nxt = dplc_pkg::DPLC_DIS;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= dplc_pkg::DPLC_DIS;
      id_r <= 2'h0;
      integ_r <= 1'b0;
      count_r <= 3'h1;
      phase_on_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == dplc_pkg::DPLC_IDM && adc_vld_s) begin
        id_r <= adc_code_s[1:0];
        integ_r <= adc_code_s[dplc_pkg::ID_INTEG_BIT];
      end
      if (cfgd && cmd_cnt) count_r <= 3'(len_r - dplc_pkg::CMD_CNT_BASE);
      if (st_nxt != dplc_pkg::DPLC_RUN) phase_on_r <= 1'b0;
      else if (st_r == dplc_pkg::DPLC_RUN && cmd_on) phase_on_r <= 1'b1;
      else if (st_r == dplc_pkg::DPLC_RUN && cmd_shed) phase_on_r <= 1'b0;
    end
  end

  // Query answer: line low during own slot (own ID, or slot 0 if integrated)
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
      fc_r <= 3'h0;
      resp_r <= 1'b0;
    end else begin
      if (!cfgd) begin
        armed_r <= 1'b0;
      end else if (cmd_query) begin
        armed_r <= 1'b1;
        fc_r <= 3'h0;
      end else if (armed_r && dif_fall) begin
        fc_r <= fc_r + 3'h1;
        if (fc_r == dplc_pkg::RESP_END) armed_r <= 1'b0;
      end
      resp_r <= armed_r & cfgd & (fc_r == {1'b0, slot} + 3'h1);
    end
  end

  // Set beats clear; only a rail power cycle releases it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) tsd_r <= 1'b0;
    else if (temp_s) tsd_r <= 1'b1;
    else if (!rail_s) tsd_r <= 1'b0;
  end
endmodule
`default_nettype wire

// file: verification/dplc_link_sva.sv
// Checker on the link wires between the host and device ends.
// Assumes both ends share one core clock and reset.
`timescale 1ns/1ps
`default_nettype none
module dplc_link_sva (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic timing_duty_line,
  input wire logic host_ctl_oe_n,
  input wire logic dev_ctl_oe_n,
  input wire logic ctl_handshake_line
);
  logic [8:0] low_cnt_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Length of the current low stretch on the control line
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_r <= 9'h000;
    end else if (ctl_handshake_line) begin
      low_cnt_r <= 9'h000;
    end else if (low_cnt_r != 9'h1ff) begin
      low_cnt_r <= low_cnt_r + 9'h001;
    end
  end
  a_line_resolve: assert property (ctl_handshake_line == (host_ctl_oe_n & dev_ctl_oe_n))
    else $error("control line level wrong");
  a_reset_release: assert property ($rose(nrst) |-> dev_ctl_oe_n && !timing_duty_line)
    else $error("link not idle after reset");
  a_off_timing_low: assert property (low_cnt_r >= 9'h12c |-> !timing_duty_line)
    else $error("timing clock runs while disabled");
  a_timing_high_max: assert property ($rose(timing_duty_line) |-> ##[1:10] !timing_duty_line)
    else $error("timing high phase too long");
  a_min_period: assert property ($rose(timing_duty_line) |=> (!$rose(timing_duty_line)) [*3])
    else $error("timing period too short");
  a_timing_runs: assert property ($fell(timing_duty_line) && ctl_handshake_line |->
    ##[1:16] (timing_duty_line || !host_ctl_oe_n))
    else $error("timing clock stalled");
  a_resp_window: assert property ($fell(dev_ctl_oe_n) |->
    (!dev_ctl_oe_n) [*3] ##[1:24] dev_ctl_oe_n)
    else $error("device answer length wrong");
  a_resp_host_idle: assert property (!dev_ctl_oe_n |-> host_ctl_oe_n)
    else $error("device pulls during host command");
  cover property ($fell(dev_ctl_oe_n));
  cover property ($rose(host_ctl_oe_n));
  cover property (low_cnt_r == 9'h12c);
endmodule
`default_nettype wire

// file: verification/dpu_phase_link_control_bench.sv
// Bench joining host and device ends over one link.
// Assumes a 20 MHz core clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
module dpu_phase_link_control_bench;
  typedef struct packed {logic [1:0] kind; logic [3:0] val;} dplc_note_t;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic rail_en = 1'b0;
  logic rail_on = 1'b0;
  logic over_temp = 1'b0;
  logic id_adc_valid = 1'b0;
  logic [2:0] phases_req = 3'h0;
  logic [2:0] id_adc_code = 3'h0;
  logic [4:0] duty_hi = 5'h02;
  logic [2:0] dev_count, phases_on, prev_on;
  logic [1:0] device_id;
  logic init_done, id_src_en, sw_high, sw_low, phase_active, configured, thermal_off;
  logic prev_init, prev_th;
  logic [7:0] rnd = 8'h52;
  int errors = 0;
  int samples_checked = 0;
  dplc_note_t notes[$];
  always #25 core_clk = ~core_clk;
  dplc_link_if link ();
  dplc_host i_dplc_host (.core_clk(core_clk), .nrst(nrst), .link(link), .rail_en(rail_en),
    .phases_req(phases_req), .duty_hi(duty_hi), .dev_count(dev_count),
    .init_done(init_done), .phases_on(phases_on));
  dplc_dev i_dplc_dev (.core_clk(core_clk), .nrst(nrst), .link(link),
    .id_adc_code(id_adc_code), .id_adc_valid(id_adc_valid), .id_src_en(id_src_en),
    .over_temp(over_temp), .rail_on(rail_on), .sw_high(sw_high), .sw_low(sw_low),
    .phase_active(phase_active), .device_id(device_id), .configured(configured),
    .thermal_off(thermal_off));
  dplc_link_sva i_dplc_link_sva (.core_clk(core_clk), .nrst(nrst),
    .timing_duty_line(link.timing_duty_line), .host_ctl_oe_n(link.host_ctl_oe_n),
    .dev_ctl_oe_n(link.dev_ctl_oe_n), .ctl_handshake_line(link.ctl_handshake_line));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checked %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic pop_check(input logic [1:0] kind, input logic [3:0] val);
    dplc_note_t nt;
    if (notes.size() == 0) begin
      errors++;
      $display("[FAIL] %0t ns: unexpected output change", $time);
    end else begin
      nt = notes.pop_front();
      check({2'b00, kind, val}, {2'b00, nt.kind, nt.val});
    end
  endtask
  // Result watcher: each output change consumes the oldest note
  always @(negedge core_clk) begin
    if (nrst) begin
      if (init_done !== prev_init) pop_check(2'd0, {3'h0, init_done});
      if (phases_on !== prev_on) pop_check(2'd1, {1'b0, phases_on});
      if (thermal_off !== prev_th) pop_check(2'd2, {3'h0, thermal_off});
    end
    prev_init = init_done;
    prev_on = phases_on;
    prev_th = thermal_off;
  end
  task automatic wait_drain(input int lim);
    int n;
    n = 0;
    while (notes.size() > 0 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (notes.size() > 0) begin
      errors++;
      $display("[FAIL] %0t ns: expected output change missing", $time);
      notes.delete();
    end
  endtask
  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    while (link.timing_duty_line !== lvl && n < 60) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic timing_period(output int per);
    int a, b;
    wait_lvl(1'b0, a);
    wait_lvl(1'b1, a);
    wait_lvl(1'b0, a);
    wait_lvl(1'b1, b);
    per = a + b;
  endtask
  // High cycles and pulse count over 20 switching periods
  task automatic measure(output int width, output int pulses);
    logic prev_sw;
    width = 0;
    pulses = 0;
    prev_sw = sw_high;
    for (int n = 0; n < 200; n++) begin
      @(negedge core_clk);
      if (sw_high === 1'b1) width++;
      if (sw_high === 1'b1 && prev_sw === 1'b0) pulses++;
      prev_sw = sw_high;
    end
  endtask
  // Separate mode: single unit must be ID 0; integrated mode: any ID, slot 0
  task automatic bring_up(input logic integ);
    logic [1:0] id;
    int n;
    rnd = lfsr(rnd);
    id = integ ? rnd[1:0] : 2'h0;
    id_adc_code = {integ, id};
    id_adc_valid = 1'b0;
    rail_on = 1'b1;
    rail_en = 1'b1;
    n = 0;
    while (id_src_en !== 1'b1 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    check({7'h0, id_src_en}, 8'h01);
    repeat (20) @(negedge core_clk);
    id_adc_valid = 1'b1;
    notes.push_back('{2'd0, 4'h1});
    wait_drain(30000);
    repeat (8) @(negedge core_clk);
    check({5'h0, dev_count}, 8'h01);
    check({6'h0, device_id}, {6'h0, id});
    check({7'h0, configured}, 8'h01);
  endtask
  initial begin
    int a, b;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    check({6'h0, configured, sw_high}, 8'h00);
    bring_up(1'b0);
    phases_req = 3'h1;
    notes.push_back('{2'd1, 4'h1});
    wait_drain(2000);
    repeat (40) @(negedge core_clk);
    check({7'h0, phase_active}, 8'h01);
    timing_period(a);
    check(8'(a), 8'(dplc_pkg::FULL_C));
    for (int d = 1; d < 5; d++) begin
      duty_hi = 5'(d);
      repeat (60) @(negedge core_clk);
      measure(a, b);
      check(8'(a), 8'(40 * ((d < 2) ? 2 : (d > 3) ? 3 : d)));
      check(8'(b), 8'h14);
    end
    phases_req = 3'h0;
    notes.push_back('{2'd1, 4'h0});
    wait_drain(2000);
    repeat (10) @(negedge core_clk);
    timing_period(a);
    check(8'(a), 8'(dplc_pkg::IDLE_C));
    measure(a, b);
    check(8'(b), 8'h00);
    rnd = lfsr(rnd);
    phases_req = rnd[2:0] | 3'h1;
    notes.push_back('{2'd1, 4'h1});
    wait_drain(2000);
    repeat (8) @(negedge core_clk);
    check({7'h0, phase_active}, 8'h01);
    over_temp = 1'b1;
    notes.push_back('{2'd2, 4'h1});
    wait_drain(100);
    over_temp = 1'b0;
    repeat (4) @(negedge core_clk);
    measure(a, b);
    check(8'(b), 8'h00);
    check({6'h0, sw_high, sw_low}, 8'h00);
    phases_req = 3'h0;
    notes.push_back('{2'd1, 4'h0});
    wait_drain(2000);
    rail_en = 1'b0;
    notes.push_back('{2'd0, 4'h0});
    wait_drain(100);
    rail_on = 1'b0;
    notes.push_back('{2'd2, 4'h0});
    wait_drain(100);
    repeat (900) @(negedge core_clk);
    check({7'h0, configured}, 8'h00);
    bring_up(1'b1);
    phases_req = 3'h1;
    notes.push_back('{2'd1, 4'h1});
    wait_drain(2000);
    repeat (8) @(negedge core_clk);
    check({7'h0, phase_active}, 8'h01);
    end_sim();
  end
  initial begin
    #(40000 * 50);
    errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
